// [src/hacd_core.sv]
// Core execution datapath: fetch/execute pipeline, accumulator and ALU
//
// Contract
// - Plain instructions finish in one cycle, flow changes in two.
// - Every instruction is one 12-bit word.
// - One whole 12-bit word is fetched per cycle on a dedicated program bus.
// - Fetching the next word overlaps executing the current one.
// - The program counter spans 512 words or 2048 words depending on variant.
// - Program and data memory use separate buses and work in the same cycle.
// - Special function registers, the counter included, sit in data space.
// - The ALU is 8 bits wide with add, subtract, shift and logic operations.
// - Arithmetic is two's complement.
// - Two-operand work uses the accumulator and a file register or literal.
// - Single-operand work uses the accumulator or a file register.
// - The accumulator is an 8-bit register with no data-space address.
// - Results update carry, digit carry and zero as the operation dictates.
// - On subtraction carry and digit carry are inverted borrows.
module hacd_core #(
    parameter int PC_W = hacd_pkg::PC_W_LARGE
) (
    input  wire logic        clk,
    input  wire logic        rst,
    output logic [PC_W-1:0]  prog_addr,
    input  wire logic [11:0] prog_data,
    output logic [7:0]       accum,
    output logic [7:0]       status,
    output logic             branch_taken
);
    initial begin
        if (PC_W != hacd_pkg::PC_W_SMALL && PC_W != hacd_pkg::PC_W_LARGE)
            $error("hacd_core: PC_W must be 9 or 11");
    end

    hacd_file_if fport ();
    hacd_file_mem #(.DEPTH(hacd_pkg::FILE_DEPTH)) u_mem (.clk(clk), .port(fport));

    hacd_pkg::hacd_state_t state;
    logic [PC_W-1:0] pc;
    logic [11:0]     ir;
    logic [7:0]      fsr;
    logic [7:0]      w;

    // ALU evaluation: returns {carry, digit, result}
    function automatic logic [9:0] alu(input hacd_pkg::hacd_alu_op_t op,
                                       input logic [7:0] a, input logic [7:0] b,
                                       input logic c_in);
        logic [8:0] s;
        logic [4:0] n;
        s = 9'h000;
        n = 5'h00;
        case (op)
            hacd_pkg::HACD_ALU_ADD: begin
                s = {1'b0, a} + {1'b0, b};
                n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
            end
            hacd_pkg::HACD_ALU_SUB: begin
                // f - w as f + ~w + 1: carry out is the inverted borrow
                s = {1'b0, b} + {1'b0, ~a} + 9'h001;
                n = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
            end
            hacd_pkg::HACD_ALU_PASS_W: s = {1'b0, a};
            hacd_pkg::HACD_ALU_PASS_F: s = {1'b0, b};
            hacd_pkg::HACD_ALU_AND:    s = {1'b0, a & b};
            hacd_pkg::HACD_ALU_OR:     s = {1'b0, a | b};
            hacd_pkg::HACD_ALU_XOR:    s = {1'b0, a ^ b};
            hacd_pkg::HACD_ALU_COM:    s = {1'b0, ~b};
            hacd_pkg::HACD_ALU_INC:    s = {1'b0, b + 8'h01};
            hacd_pkg::HACD_ALU_DEC:    s = {1'b0, b - 8'h01};
            hacd_pkg::HACD_ALU_RLF:    s = {b, c_in};
            hacd_pkg::HACD_ALU_RRF:    s = {b[0], c_in, b[7:1]};
            hacd_pkg::HACD_ALU_SWAP:   s = {1'b0, b[3:0], b[7:4]};
            hacd_pkg::HACD_ALU_CLR:    s = 9'h000;
            default:                   s = 9'h000;
        endcase
        return {s[8], n[4], s[7:0]};
    endfunction

    // Instruction decode of the word in execute
    wire        exec_valid = (state == hacd_pkg::HACD_ST_RUN);
    wire        is_goto    = (ir & hacd_pkg::OP_GOTO_MASK) == hacd_pkg::OP_GOTO;
    wire        is_call    = ir[11:8] == 4'h9;
    wire        is_retlw   = ir[11:8] == 4'h8;
    wire [3:0]  lit_op     = ir[11:8];
    wire        is_lit     = ir[11:10] == 2'b11;
    wire        is_bitop   = ir[11:10] == 2'b01;
    wire        is_byte    = ir[11:10] == 2'b00;
    wire [3:0]  byte_op    = ir[9:6];
    wire        dest_f     = ir[5];
    wire [4:0]  f_field    = ir[4:0];
    wire [7:0]  lit        = ir[7:0];

    // Indirect access goes through the pointer register
    wire [6:0]  f_addr     = (f_field == 5'h00) ? fsr[6:0] : {2'b00, f_field};
    logic [7:0] fwd_data;
    logic [6:0] fwd_addr;
    logic       fwd_valid;
    wire [7:0]  mem_f      = (fwd_valid && fwd_addr == f_addr) ? fwd_data : fport.rdata;
    wire [7:0]  f_val      = (f_addr == hacd_pkg::ADDR_PCL)    ? 8'(pc) :
                             (f_addr == hacd_pkg::ADDR_STATUS) ? status :
                             (f_addr == hacd_pkg::ADDR_FSR)    ? fsr : mem_f;

    hacd_pkg::hacd_alu_op_t op;
    logic       upd_z;
    logic       upd_c;
    logic       upd_dc;
    logic       to_w;
    logic       to_f;
    always_comb begin
        op = hacd_pkg::HACD_ALU_PASS_W;
        upd_z = 1'b0;
        upd_c = 1'b0;
        upd_dc = 1'b0;
        to_w = 1'b0;
        to_f = 1'b0;
        if (is_byte) begin
            to_w = !dest_f;
            to_f = dest_f;
            upd_z = 1'b1;
            case (byte_op)
                4'h0: begin op = hacd_pkg::HACD_ALU_PASS_W; to_f = dest_f; upd_z = 1'b0; end
                4'h1: begin op = hacd_pkg::HACD_ALU_CLR; end
                4'h2: begin op = hacd_pkg::HACD_ALU_SUB; upd_c = 1'b1; upd_dc = 1'b1; end
                4'h3: op = hacd_pkg::HACD_ALU_DEC;
                4'h4: op = hacd_pkg::HACD_ALU_OR;
                4'h5: op = hacd_pkg::HACD_ALU_AND;
                4'h6: op = hacd_pkg::HACD_ALU_XOR;
                4'h7: begin op = hacd_pkg::HACD_ALU_ADD; upd_c = 1'b1; upd_dc = 1'b1; end
                4'h8: op = hacd_pkg::HACD_ALU_PASS_F;
                4'h9: op = hacd_pkg::HACD_ALU_COM;
                4'ha: op = hacd_pkg::HACD_ALU_INC;
                4'hc: begin op = hacd_pkg::HACD_ALU_RRF; upd_z = 1'b0; upd_c = 1'b1; end
                4'hd: begin op = hacd_pkg::HACD_ALU_RLF; upd_z = 1'b0; upd_c = 1'b1; end
                4'he: begin op = hacd_pkg::HACD_ALU_SWAP; upd_z = 1'b0; end
                default: begin to_w = 1'b0; to_f = 1'b0; upd_z = 1'b0; end
            endcase
            if (ir[11:5] == 7'h00) begin
                to_w = 1'b0;
                to_f = 1'b0;
            end
        end else if (is_lit) begin
            to_w = 1'b1;
            upd_z = lit_op != 4'hc;
            case (lit_op)
                4'hc: op = hacd_pkg::HACD_ALU_PASS_F;
                4'hd: op = hacd_pkg::HACD_ALU_OR;
                4'he: op = hacd_pkg::HACD_ALU_AND;
                default: op = hacd_pkg::HACD_ALU_XOR;
            endcase
        end else if (is_retlw) begin
            to_w = 1'b1;
            op = hacd_pkg::HACD_ALU_PASS_F;
        end
    end

    wire [7:0] alu_b = (is_lit || is_retlw) ? lit : f_val;
    // Bit set and clear reuse the file write path
    wire [7:0] bit_mask = 8'h01 << ir[7:5];
    wire [7:0] bit_res  = ir[8] ? (f_val | bit_mask) : (f_val & ~bit_mask);
    wire       bit_skip = (ir[9:8] == 2'b10 && !f_val[ir[7:5]]) ||
                          (ir[9:8] == 2'b11 && f_val[ir[7:5]]);
    wire [9:0] alu_out  = alu(op, w, alu_b, status[hacd_pkg::STAT_CARRY]);
    wire [7:0] result   = alu_out[7:0];
    wire       res_zero = result == 8'h00;
    wire       skip_z   = is_byte && (byte_op == 4'hb || byte_op == 4'hf) && dest_f == dest_f &&
                          ((byte_op == 4'hb) ? (f_val - 8'h01) == 8'h00 : (f_val + 8'h01) == 8'h00);
    wire [7:0] skz_res  = (byte_op == 4'hb) ? f_val - 8'h01 : f_val + 8'h01;
    wire       skz_op   = is_byte && (byte_op == 4'hb || byte_op == 4'hf);
    wire       wr_f     = exec_valid && (((to_f || skz_op) && is_byte) || (is_bitop && !ir[9]));
    wire [7:0] wr_data  = is_bitop ? bit_res : (skz_op ? skz_res : result);
    wire       wr_w     = exec_valid && (to_w || (skz_op && !dest_f));
    wire       pc_write = wr_f && f_addr == hacd_pkg::ADDR_PCL;

    // Any flow change or skip costs the fetched word
    assign branch_taken = exec_valid && (is_goto || is_call || is_retlw || pc_write ||
                          (is_bitop && ir[9] && bit_skip) || skip_z);
    wire [PC_W-1:0] target = is_goto ? PC_W'(ir[8:0]) :
                             is_call ? PC_W'(ir[7:0]) :
                             pc_write ? PC_W'(wr_data) : pc + PC_W'(1);
    wire [PC_W-1:0] next_pc = (branch_taken && !skip_z && !(is_bitop && ir[9])) ? target
                                                                            : pc + PC_W'(1);

    assign prog_addr = pc;
    assign fport.addr  = wr_f ? f_addr : (exec_valid ? f_addr : 7'h00);
    // Read data is registered, so the operand is read while its word is being fetched
    wire [4:0] nxt_field = prog_data[4:0];
    wire [7:0] fsr_now   = (wr_f && f_addr == hacd_pkg::ADDR_FSR) ? wr_data : fsr;
    assign fport.raddr = (nxt_field == 5'h00) ? fsr_now[6:0] : {2'b00, nxt_field};
    assign fport.wdata = wr_data;
    assign fport.we    = wr_f && f_addr > hacd_pkg::ADDR_FSR;
    assign accum = w;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= hacd_pkg::HACD_ST_RESET;
            pc <= '0;
            ir <= hacd_pkg::NOP_WORD;
        end else begin
            pc <= next_pc;
            // Flush replaces the fetched word with a no-operation
            ir <= branch_taken ? hacd_pkg::NOP_WORD : prog_data;
            state <= branch_taken ? hacd_pkg::HACD_ST_FLUSH : hacd_pkg::HACD_ST_RUN;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            w <= 8'h00;
        end else if (wr_w) begin
            w <= skz_op ? skz_res : result;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fsr <= 8'h00;
            status <= hacd_pkg::STATUS_RESET;
            fwd_valid <= 1'b0;
            fwd_addr <= 7'h00;
            fwd_data <= 8'h00;
        end else begin
            fwd_valid <= fport.we;
            fwd_addr <= f_addr;
            fwd_data <= wr_data;
            if (wr_f && f_addr == hacd_pkg::ADDR_FSR) fsr <= wr_data;
            if (wr_f && f_addr == hacd_pkg::ADDR_STATUS) begin
                status <= wr_data;
            end else if (exec_valid) begin
                if (upd_c) status[hacd_pkg::STAT_CARRY] <= alu_out[9];
                if (upd_dc) status[hacd_pkg::STAT_DIGIT] <= alu_out[8];
                if (upd_z) status[hacd_pkg::STAT_ZERO] <= res_zero;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    flush_after_branch_a: assert property (branch_taken |=> state == hacd_pkg::HACD_ST_FLUSH)
        else $error("no flush after branch");
    flush_no_exec_a: assert property (state == hacd_pkg::HACD_ST_FLUSH |-> !wr_w && !fport.we)
        else $error("flushed word executed");
    single_cycle_a: assert property (exec_valid && !branch_taken |=> state == hacd_pkg::HACD_ST_RUN)
        else $error("plain instruction stalled");
    pc_step_a: assert property (exec_valid && !branch_taken |=> pc == $past(pc) + PC_W'(1))
        else $error("pc did not advance");
    goto_target_a: assert property (exec_valid && is_goto |=> pc == PC_W'($past(ir[8:0])))
        else $error("goto target wrong");
    add_carry_a: assert property (exec_valid && is_byte && byte_op == 4'h7 |=>
        status[hacd_pkg::STAT_CARRY] == ($past({1'b0, w}) + $past({1'b0, f_val}) > 9'h0ff))
        else $error("add carry wrong");
    sub_borrow_a: assert property (exec_valid && is_byte && byte_op == 4'h2 && !(dest_f && f_addr == hacd_pkg::ADDR_STATUS) |=>
        status[hacd_pkg::STAT_CARRY] == ($past(f_val) >= $past(w)))
        else $error("sub borrow wrong");
    zero_flag_a: assert property (exec_valid && upd_z && !(wr_f && f_addr == hacd_pkg::ADDR_STATUS) |=>
        status[hacd_pkg::STAT_ZERO] == ($past(result) == 8'h00))
        else $error("zero flag wrong");
    movlw_load_a: assert property (exec_valid && is_lit && lit_op == 4'hc |=> w == $past(lit))
        else $error("literal not loaded");

    cover_branch_c: cover property (branch_taken ##1 state == hacd_pkg::HACD_ST_FLUSH ##1 exec_valid);
    cover_add_c: cover property (exec_valid && is_byte && byte_op == 4'h7);
    cover_sub_c: cover property (exec_valid && is_byte && byte_op == 4'h2 && !status[0]);
endmodule

// [src/hacd_file_if.sv]
// Interface carrying data memory port signals between core and file memory
interface hacd_file_if;
    logic [6:0] addr;
    logic [6:0] raddr;
    logic [7:0] wdata;
    logic       we;
    logic [7:0] rdata;
    modport core (output addr, output raddr, output wdata, output we, input rdata);
    modport mem  (input addr, input raddr, input wdata, input we, output rdata);
endinterface

// [src/hacd_file_mem.sv]
// Register file memory with registered read data
module hacd_file_mem #(
    parameter int DEPTH = 128
) (
    input  wire logic clk,
    hacd_file_if.mem  port
);
    logic [7:0] mem [DEPTH];
    logic [7:0] rdata_q;

    initial begin
        if (DEPTH < 8 || DEPTH > 128) $error("hacd_file_mem: DEPTH out of range");
    end

    // Read-during-write returns the old value; the core forwards around it
    always_ff @(posedge clk) begin
        if (port.we) begin
            mem[port.addr] <= port.wdata;
        end
        rdata_q <= mem[port.raddr];
    end

    assign port.rdata = rdata_q;
endmodule

// [src/hacd_pkg.sv]
// Package of constants and types for the core execution datapath
package hacd_pkg;
    localparam int INSTR_W       = 12;
    localparam int DATA_W        = 8;
    localparam int PC_W_SMALL    = 9;
    localparam int PC_W_LARGE    = 11;
    localparam int FILE_ADDR_W   = 7;
    localparam int FILE_DEPTH    = 128;
    // Special function register addresses in data space
    localparam logic [6:0] ADDR_INDF   = 7'h00;
    localparam logic [6:0] ADDR_PCL    = 7'h02;
    localparam logic [6:0] ADDR_STATUS = 7'h03;
    localparam logic [6:0] ADDR_FSR    = 7'h04;
    // Status field positions
    localparam int STAT_CARRY    = 0;
    localparam int STAT_DIGIT    = 1;
    localparam int STAT_ZERO     = 2;
    localparam logic [7:0] STATUS_RESET = 8'h18;
    localparam logic [11:0] NOP_WORD    = 12'h000;
    // Opcode patterns
    localparam logic [11:0] OP_GOTO_MASK = 12'he00;
    localparam logic [11:0] OP_GOTO      = 12'ha00;
    localparam logic [11:0] OP_LIT_MASK  = 12'hf00;
    localparam logic [11:0] OP_MOVLW     = 12'hc00;
    localparam logic [11:0] OP_IORLW     = 12'hd00;
    localparam logic [11:0] OP_ANDLW     = 12'he00;
    localparam logic [11:0] OP_XORLW     = 12'hf00;

    typedef enum logic [3:0] {
        HACD_ALU_PASS_W = 4'h0,
        HACD_ALU_PASS_F = 4'h1,
        HACD_ALU_ADD    = 4'h2,
        HACD_ALU_SUB    = 4'h3,
        HACD_ALU_AND    = 4'h4,
        HACD_ALU_OR     = 4'h5,
        HACD_ALU_XOR    = 4'h6,
        HACD_ALU_COM    = 4'h7,
        HACD_ALU_INC    = 4'h8,
        HACD_ALU_DEC    = 4'h9,
        HACD_ALU_RLF    = 4'ha,
        HACD_ALU_RRF    = 4'hb,
        HACD_ALU_SWAP   = 4'hc,
        HACD_ALU_CLR    = 4'hd
    } hacd_alu_op_t;

    typedef enum logic [1:0] {
        HACD_ST_RESET = 2'b00,
        HACD_ST_RUN   = 2'b01,
        HACD_ST_FLUSH = 2'b11
    } hacd_state_t;
endpackage

// [verification/hacd_core_tb.sv]
// Self-checking bench for the core datapath with a program memory model
module hacd_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int          PW   = hacd_pkg::PC_W_LARGE;
    localparam logic [11:0] FREG = 12'h010;
    logic            clk = 1'b0;
    logic            rst = 1'b1;
    logic [PW-1:0]   prog_addr;
    logic [11:0]     prog_data;
    logic [7:0]      accum;
    logic [7:0]      status;
    logic            branch_taken;
    logic [10:0]     exp_q [$];
    int              miscompares = 0;
    int              samples_checked = 0;
    logic [7:0]      seed = 8'h3d;
    logic [7:0]      w;
    logic [7:0]      fr;
    logic            c;
    logic            dc;
    logic            z;
    int              pc;
    logic            fe_v;
    logic            ex_v;
    logic            pend;
    logic            fl;
    logic [11:0]     fe_w;
    logic [11:0]     ex_w;
    logic [PW-1:0]   exp_pc;
    logic [15:0]     ab;
    logic [15:0]     pairs [6] = '{16'h0000, 16'hff01, 16'h0f01, 16'h8080, 16'h0102, 16'h10ff};

    always #12.5 clk = ~clk;

    hacd_core #(.PC_W(PW)) hacd_core_i (.clk(clk), .rst(rst), .prog_addr(prog_addr),
        .prog_data(prog_data), .accum(accum), .status(status), .branch_taken(branch_taken));
    hacd_prog_rom #(.PC_W(PW)) hacd_prog_rom_i (.prog_addr(prog_addr), .prog_data(prog_data));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic logic is_goto(input logic [11:0] iw);
        return (iw & hacd_pkg::OP_GOTO_MASK) == hacd_pkg::OP_GOTO;
    endfunction

    task automatic cmp_res(input logic [10:0] act, input logic [10:0] exp);
        samples_checked++;
        if (act !== exp) begin
            miscompares++;
            $display("[ERR] %0t result act=%h exp=%h", $time, act, exp);
        end
    endtask

    task automatic cmp_ctl(input logic [11:0] act, input logic [11:0] exp);
        samples_checked++;
        if (act !== exp) begin
            miscompares++;
            $display("[ERR] %0t control act=%h exp=%h", $time, act, exp);
        end
    endtask

    task automatic put(input logic [11:0] iw, input logic note);
        hacd_prog_rom_i.mem[pc] = iw;
        pc++;
        if (note) exp_q.push_back({w, z, dc, c});
    endtask

    task automatic lit(input logic [11:0] op, input logic [7:0] k);
        case (op)
            hacd_pkg::OP_MOVLW: w = k;
            hacd_pkg::OP_IORLW: w = w | k;
            hacd_pkg::OP_ANDLW: w = w & k;
            default: w = w ^ k;
        endcase
        if (op != hacd_pkg::OP_MOVLW) z = (w == 8'h00);
        put(op | {4'h0, k}, 1'b1);
    endtask

    task automatic rlit(input logic [11:0] op);
        seed = lfsr(seed);
        lit(op, seed);
    endtask

    task automatic arith(input logic sub);
        logic [8:0] r;
        r = sub ? {1'b0, fr} - {1'b0, w} : {1'b0, fr} + {1'b0, w};
        dc = sub ? (fr[3:0] >= w[3:0]) : ({1'b0, fr[3:0]} + {1'b0, w[3:0]} > 5'h0f);
        c = sub ? ~r[8] : r[8];
        w = r[7:0];
        z = (w == 8'h00);
        put((sub ? 12'h080 : 12'h1c0) | FREG, 1'b1);
    endtask

    // The skipped slot holds a poison word so a missed flush shows in the accumulator
    task automatic jump(input int t);
        hacd_prog_rom_i.mem[pc] = hacd_pkg::OP_GOTO | 12'(t);
        hacd_prog_rom_i.mem[pc + 1] = hacd_pkg::OP_MOVLW | 12'h0ff;
        pc = t;
    endtask

    task automatic start_test(input int hold);
        rst <= 1'b1;
        repeat (hold) @(posedge clk);
        #1;
        cmp_ctl({accum, branch_taken, 3'h0}, 12'h000);
        cmp_ctl({4'h0, status}, {4'h0, hacd_pkg::STATUS_RESET});
        for (int i = 0; i < (1 << PW); i++) hacd_prog_rom_i.mem[i] = hacd_pkg::NOP_WORD;
        pc = 0;
        w = 8'h00;
        {z, dc, c} = hacd_pkg::STATUS_RESET[2:0];
        exp_q.delete();
    endtask

    task automatic run_test(input string name);
        int n;
        int halt;
        halt = pc;
        jump(pc);
        n = 0;
        @(posedge clk);
        rst <= 1'b0;
        while (prog_addr !== PW'(halt) && n < 400) begin
            @(negedge clk);
            n++;
        end
        repeat (6) @(negedge clk);
        cmp_ctl(12'(exp_q.size()), 12'h000);
        $display("test %s done", name);
    endtask

    // Own copy of the fetch/execute pipe; pops one note per finished instruction other than a goto
    always @(negedge clk) begin
        if (rst) begin
            fe_v = 1'b0;
            ex_v = 1'b0;
            pend = 1'b0;
            exp_pc = '1;
        end else begin
            if (pend) cmp_res({accum, status[2:0]}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
            fl = ex_v && is_goto(ex_w);
            exp_pc = fl ? PW'(ex_w[8:0]) : exp_pc + 1'b1;
            ex_v = fe_v && !fl;
            ex_w = fe_w;
            cmp_ctl(12'(branch_taken), 12'(ex_v && is_goto(ex_w)));
            cmp_ctl(12'(prog_addr), 12'(exp_pc));
            pend = ex_v && !is_goto(ex_w);
            fe_w = prog_data;
            fe_v = 1'b1;
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #(25 * 4000);
        miscompares++;
        end_sim();
    end

    initial begin
        start_test(12);
        for (int i = 0; i < 4; i++) begin
            rlit(hacd_pkg::OP_MOVLW);
            rlit(hacd_pkg::OP_IORLW);
            rlit(hacd_pkg::OP_ANDLW);
            lit(hacd_pkg::OP_XORLW, i[0] ? w : seed);
        end
        run_test("literal");
        start_test(2);
        for (int i = 0; i < 10; i++) begin
            seed = lfsr(seed);
            ab = (i < 6) ? pairs[i] : {seed, lfsr(seed)};
            lit(hacd_pkg::OP_MOVLW, ab[15:8]);
            fr = w;
            put(12'h020 | FREG, 1'b1);
            lit(hacd_pkg::OP_MOVLW, ab[7:0]);
            arith(1'b0);
            lit(hacd_pkg::OP_MOVLW, ab[7:0]);
            arith(1'b1);
        end
        run_test("arith");
        start_test(2);
        rlit(hacd_pkg::OP_MOVLW);
        jump(pc + 2);
        rlit(hacd_pkg::OP_XORLW);
        jump(pc + 5);
        jump(40);
        rlit(hacd_pkg::OP_IORLW);
        jump(20);
        rlit(hacd_pkg::OP_MOVLW);
        run_test("branch");
        end_sim();
    end
endmodule

// [verification/hacd_prog_rom.sv]
// Program memory model answering each fetch within the same cycle
module hacd_prog_rom #(
    parameter int PC_W = hacd_pkg::PC_W_LARGE
) (
    input  wire logic [PC_W-1:0] prog_addr,
    output logic [11:0]          prog_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] mem [0:(1<<PC_W)-1];
    // One whole word per address on its own bus, so no fetch straddles words
    assign prog_data = mem[prog_addr];
endmodule
